/* File: common/tde_pkg.sv */
// Timing, stream and backlight constants for the TFT data-enable driver
package tde_pkg;
    // Panel picture and blanking, in dot clocks and lines
    localparam int unsigned H_ACTIVE      = 480;
    localparam int unsigned H_BLANK       = 45;
    localparam int unsigned H_TOTAL       = H_ACTIVE + H_BLANK;
    localparam int unsigned V_ACTIVE      = 272;
    localparam int unsigned V_BLANK_MIN   = 13;
    // Tall vertical blank so about 40 % of each frame is free for memory
    localparam int unsigned V_BLANK       = 181;
    localparam int unsigned V_TOTAL       = V_ACTIVE + V_BLANK;
    localparam int unsigned FRAME_HZ      = 60;
    // Dot rate the source must supply for the nominal refresh
    localparam int unsigned DOT_HZ        = H_TOTAL * V_TOTAL * FRAME_HZ;
    localparam int unsigned H_W           = 10;
    localparam int unsigned V_W           = 9;
    localparam logic [H_W-1:0] H_LAST     = H_W'(H_TOTAL - 1);
    localparam logic [H_W-1:0] H_ACT_END  = H_W'(H_ACTIVE);
    localparam logic [V_W-1:0] V_LAST     = V_W'(V_TOTAL - 1);
    localparam logic [V_W-1:0] V_ACT_END  = V_W'(V_ACTIVE);

    // Pixel word, 5-6-5 colour
    localparam int unsigned PIX_W         = 16;
    localparam int unsigned BUF_DEPTH     = 2;

    // Backlight modulator
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam int unsigned BL_STEP_HZ    = 1000;
    localparam int unsigned BL_STEP_MAX_HZ = 16000;
    localparam int unsigned BL_STEP_CYC   = SYS_CLK_HZ / BL_STEP_HZ;
    localparam int unsigned BL_STEP_MIN_CYC =
        (SYS_CLK_HZ + BL_STEP_MAX_HZ - 1) / BL_STEP_MAX_HZ;
    localparam int unsigned BL_DIV_W      = 17;
    localparam int unsigned BL_STEPS      = 16;
    localparam int unsigned BL_STEP_W     = 4;
    localparam int unsigned BL_DUTY_W     = 5;
    localparam logic [BL_DUTY_W-1:0] BL_DUTY_FULL = BL_DUTY_W'(BL_STEPS);
    localparam logic [BL_DUTY_W-1:0] BL_DUTY_OFF  = 5'h00;

    // Sync pins are active low and held inactive
    localparam logic SYNC_IDLE            = 1'b1;
    localparam logic BL_OFF               = 1'b0;
endpackage

/* File: rtl/tde_timing.sv */
// TFT data-enable timing generator with pixel buffer and backlight PWM
// Operation
// - Picture is 480 pixels per line and 272 lines per frame.
// - Each pixel goes out as one 16-bit 5-6-5 word.
// - Pixel data and timing run continuously, never paused.
// - Backlight output high means on, low means off.
// - Backlight output is low during reset; after reset it follows bl_duty_i from the next cycle, with no wait for initialisation.
// - Backlight PWM steps at 1 kHz, 16 steps, 62.5 Hz period.
// - Backlight step clock is 1 kHz by default; no check holds BL_DIV_CYCLES to the 16 kHz limit.
// - Pixels advance only at dot clock rate, lines in order.
// - Frame refresh near 60 Hz, painting about half of it.
// - Block flags the vertical blanking window when memory access is free.
// - Frame and line sync outputs held permanently inactive.
// - Pixel-valid is high exactly while pixels are clocked in.
// - Pixel-valid low at least 45 dot clocks between lines.
// - Pixel-valid low at least 13 lines before each frame except the first after reset, which gets one line.
`timescale 1ns/10ps

module tde_pix_buf
    import tde_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [PIX_W-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [PIX_W-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [PIX_W-1:0] mem_reg [0:BUF_DEPTH-1];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = mem_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end

    // Storage needs no reset; empty slots are never read as valid
    always_ff @(posedge sys_clk_i) begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data_i;
    end
endmodule

module tde_timing
    import tde_pkg::*;
#(
    parameter logic [BL_DIV_W-1:0] BL_DIV_CYCLES = BL_DIV_W'(BL_STEP_CYC)
)
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 dot_clk_i,
    input  wire logic [PIX_W-1:0]     pix_data_i,
    input  wire logic                 pix_valid_i,
    output logic                      pix_ready_o,
    input  wire logic [BL_DUTY_W-1:0] bl_duty_i,
    output logic      [PIX_W-1:0]     lcd_rgb_o,
    output logic                      pixel_valid_o,
    output logic                      frame_sync_n_o,
    output logic                      line_sync_n_o,
    output logic                      mem_access_ok_o,
    output logic                      underrun_o,
    output logic                      backlight_enable_out_o
);
    // Dot clock crossing: meta flop feeds only the sync flop
    logic dot_meta_reg;
    logic dot_sync_reg;
    logic dot_prev_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dot_meta_reg <= 1'b0;
            dot_sync_reg <= 1'b0;
            dot_prev_reg <= 1'b0;
        end else begin
            dot_meta_reg <= dot_clk_i;
            dot_sync_reg <= dot_meta_reg;
            dot_prev_reg <= dot_sync_reg;
        end
    end

    wire dot_en = dot_sync_reg && !dot_prev_reg;

    // Raster counters, one step per dot
    logic [H_W-1:0] h_reg;
    logic [V_W-1:0] v_reg;
    wire            h_wrap = (h_reg == H_LAST);
    wire            v_wrap = (v_reg == V_LAST);
    wire [H_W-1:0]  h_next = h_wrap ? '0 : h_reg + H_W'(1);
    wire [V_W-1:0]  v_next = !h_wrap ? v_reg : (v_wrap ? '0 : v_reg + V_W'(1));
    wire            line_active = (v_reg < V_ACT_END);
    wire            dot_active  = line_active && (h_reg < H_ACT_END);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            h_reg <= '0;
            v_reg <= V_LAST;
        end else if (dot_en) begin
            h_reg <= h_next;
            v_reg <= v_next;
        end
    end

    // Two-entry buffer between frame memory and panel
    logic [PIX_W-1:0] buf_data;
    logic             buf_valid;
    wire              buf_take = dot_en && dot_active;

    tde_pix_buf tde_pix_buf_inst (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (pix_data_i),
        .in_valid_i  (pix_valid_i),
        .in_ready_o  (pix_ready_o),
        .out_data_o  (buf_data),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_take)
    );

    // Panel outputs; an empty buffer repeats the last word so timing holds
    logic [PIX_W-1:0] rgb_reg;
    logic             valid_reg;
    logic             access_reg;
    logic             underrun_reg;
    wire              starved = buf_take && !buf_valid;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rgb_reg      <= '0;
            valid_reg    <= 1'b0;
            access_reg   <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            underrun_reg <= starved;
            if (dot_en) begin
                valid_reg  <= dot_active;
                access_reg <= !line_active;
                if (buf_take && buf_valid)
                    rgb_reg <= buf_data;
            end
        end
    end

    assign lcd_rgb_o       = rgb_reg;
    assign pixel_valid_o   = valid_reg;
    assign mem_access_ok_o = access_reg;
    assign underrun_o      = underrun_reg;
    assign frame_sync_n_o  = SYNC_IDLE;
    assign line_sync_n_o   = SYNC_IDLE;

    // Backlight step divider and PWM
    logic [BL_DIV_W-1:0]  div_reg;
    logic [BL_STEP_W-1:0] step_reg;
    logic                 bl_reg;
    wire                  step_en = (div_reg == BL_DIV_CYCLES - BL_DIV_W'(1));
    wire                  bl_on   = ({1'b0, step_reg} < bl_duty_i);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg  <= '0;
            step_reg <= '0;
            bl_reg   <= BL_OFF;
        end else begin
            div_reg <= step_en ? '0 : div_reg + BL_DIV_W'(1);
            if (step_en)
                step_reg <= step_reg + BL_STEP_W'(1);
            bl_reg <= bl_on;
        end
    end

    assign backlight_enable_out_o = bl_reg;

    // Checking helpers
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic [H_W-1:0] run_cnt;
    logic [19:0]    gap_cnt;
    logic [V_W-1:0] line_cnt;
    logic [BL_DIV_W-1:0] step_gap;
    logic           seen_step;
    logic           seen_gap;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_cnt   <= '0;
            gap_cnt   <= '0;
            line_cnt  <= '0;
            step_gap  <= '0;
            seen_step <= 1'b0;
            seen_gap  <= 1'b0;
        end else begin
            if (dot_en && valid_reg)
                run_cnt <= run_cnt + H_W'(1);
            else if (!valid_reg)
                run_cnt <= '0;
            if (dot_en && !valid_reg)
                gap_cnt <= gap_cnt + 20'h00001;
            else if (valid_reg) begin
                gap_cnt  <= '0;
                seen_gap <= seen_gap || (gap_cnt != '0);
            end
            // Lines counted at each line start; a long gap opens a frame
            if ($rose(valid_reg))
                line_cnt <= (gap_cnt > 20'(H_TOTAL)) ? V_W'(1)
                                                    : line_cnt + V_W'(1);
            // Spacing taken from the step counter, not from the divider
            step_gap <= $changed(step_reg) ? '0 : step_gap + BL_DIV_W'(1);
            if ($changed(step_reg))
                seen_step <= 1'b1;
        end
    end

    sequence s_line_end;
        $fell(valid_reg);
    endsequence

    sequence s_duty_steady(logic [BL_DUTY_W-1:0] d);
        (bl_duty_i == d) [*2];
    endsequence

    chk_sync_idle: assert property (
        frame_sync_n_o && line_sync_n_o)
        else $error("sync output left its idle level");

    chk_line_length: assert property (
        s_line_end |-> run_cnt == H_ACT_END)
        else $error("active line not 480 dots long");

    chk_line_gap: assert property (
        $rose(valid_reg) && seen_gap |-> gap_cnt >= 20'(H_BLANK))
        else $error("line gap below 45 dots");

    chk_frame_gap: assert property (
        $rose(valid_reg) && gap_cnt > 20'(H_TOTAL) && seen_gap
        |-> gap_cnt >= 20'(V_BLANK_MIN * H_TOTAL))
        else $error("frame gap below 13 lines");

    chk_frame_lines: assert property (
        $rose(valid_reg) && gap_cnt > 20'(H_TOTAL) && seen_gap
        |-> line_cnt == V_ACT_END)
        else $error("frame not 272 lines");

    chk_valid_dot: assert property (
        $changed(valid_reg) |-> $past(dot_en))
        else $error("pixel valid moved off a dot edge");

    chk_data_hold: assert property (
        $changed(rgb_reg) |-> $past(dot_en) && valid_reg)
        else $error("pixel data moved outside an active dot");

    chk_access_window: assert property (
        mem_access_ok_o |-> !pixel_valid_o)
        else $error("memory window open while painting");

    chk_access_open: assert property (
        $rose(mem_access_ok_o) |-> v_reg >= V_ACT_END)
        else $error("memory window opened inside the picture");

    chk_access_close: assert property (
        $fell(mem_access_ok_o) |-> v_reg == '0)
        else $error("memory window closed away from frame start");

    // A starved dot still counts as a painted pixel
    chk_underrun_active: assert property (
        underrun_o |-> pixel_valid_o)
        else $error("underrun flagged outside an active dot");

    chk_bl_off: assert property (
        s_duty_steady(BL_DUTY_OFF) |=> !backlight_enable_out_o)
        else $error("backlight on at zero duty");

    chk_bl_full: assert property (
        s_duty_steady(BL_DUTY_FULL) |=> backlight_enable_out_o)
        else $error("backlight off at full duty");

    chk_step_spacing: assert property (
        $changed(step_reg) && seen_step
        |-> step_gap == BL_DIV_CYCLES - BL_DIV_W'(1))
        else $error("backlight step spacing wrong");
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the TFT data-enable timing block
`timescale 1ns/10ps

module tb
    import tde_pkg::*;
;
    // Short backlight step so a PWM period fits the run
    localparam logic [BL_DIV_W-1:0] DIV = 17'h00008;
    logic                 sys_clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 dot_clk_i = 1'b0;
    logic [PIX_W-1:0]     pix_data_i = 16'h0000;
    logic                 pix_valid_i = 1'b0;
    logic                 feed_en = 1'b0;
    logic [BL_DUTY_W-1:0] bl_duty_i = 5'h00;
    logic                 pix_ready_o;
    logic [PIX_W-1:0]     lcd_rgb_o;
    logic                 pixel_valid_o;
    logic                 frame_sync_n_o;
    logic                 line_sync_n_o;
    logic                 mem_access_ok_o;
    logic                 underrun_o;
    logic                 backlight_enable_out_o;
    int                   lines;
    int                   last_run;
    int                   min_gap;
    int                   order_err;
    int                   side_err;
    int                   failures = 0;
    int                   compares = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    // Dot clock at 80 ns, phase unrelated to the system clock
    initial begin
        #3;
        forever #40 dot_clk_i = ~dot_clk_i;
    end

    // Word held until taken; a refused word is never dropped
    always @(posedge sys_clk_i) begin
        if (pix_valid_i && pix_ready_o)
            pix_data_i <= pix_data_i + 16'h0001;
        pix_valid_i <= feed_en || (pix_valid_i && !pix_ready_o);
    end

    tde_timing #(.BL_DIV_CYCLES(DIV)) tde_timing_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .dot_clk_i(dot_clk_i),
        .pix_data_i(pix_data_i), .pix_valid_i(pix_valid_i),
        .pix_ready_o(pix_ready_o), .bl_duty_i(bl_duty_i),
        .lcd_rgb_o(lcd_rgb_o), .pixel_valid_o(pixel_valid_o),
        .frame_sync_n_o(frame_sync_n_o), .line_sync_n_o(line_sync_n_o),
        .mem_access_ok_o(mem_access_ok_o), .underrun_o(underrun_o),
        .backlight_enable_out_o(backlight_enable_out_o));

    tde_panel_model tde_panel_model_inst (
        .dot_clk_i(dot_clk_i), .rgb_i(lcd_rgb_o),
        .pixel_valid_i(pixel_valid_o), .frame_sync_n_i(frame_sync_n_o),
        .line_sync_n_i(line_sync_n_o), .mem_ok_i(mem_access_ok_o),
        .lines_o(lines), .last_run_o(last_run), .min_gap_o(min_gap),
        .order_err_o(order_err), .side_err_o(side_err));

    task automatic chk_bit(string name, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_cnt(string name, int exp, int got);
        compares++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic t_reset_state();
        @(negedge sys_clk_i);
        chk_bit("backlight", BL_OFF, backlight_enable_out_o);
        chk_bit("frame_sync_n_o", SYNC_IDLE, frame_sync_n_o);
        chk_bit("line_sync_n_o", SYNC_IDLE, line_sync_n_o);
        chk_bit("pixel_valid_o", 1'b0, pixel_valid_o);
    endtask

    // Raster starts in blank, so nothing pops: two words fill it
    task automatic t_buffer_full();
        @(posedge sys_clk_i);
        feed_en <= 1'b1;
        repeat (6) @(negedge sys_clk_i);
        chk_bit("pix_ready_o", 1'b0, pix_ready_o);
        chk_bit("pixel_valid_o", 1'b0, pixel_valid_o);
    endtask

    task automatic t_backlight();
        logic [BL_DUTY_W-1:0] duty [4] = '{5'h00, 5'h08, 5'h10, 5'h14};
        int highs;
        int want;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            bl_duty_i <= duty[i];
            repeat (140) @(posedge sys_clk_i);
            highs = 0;
            want = (duty[i] > BL_DUTY_FULL) ? BL_STEPS : int'(duty[i]);
            // Any window of one PWM period holds duty steps of on time, capped at 16 steps
            repeat (BL_STEPS * DIV) begin
                @(negedge sys_clk_i);
                if (backlight_enable_out_o === 1'b1)
                    highs++;
            end
            chk_cnt("backlight_on", want * DIV, highs);
        end
        // Raster starts on a blank line, so memory is free here
        chk_bit("mem_access_ok_o", 1'b1, mem_access_ok_o);
    endtask

    task automatic t_lines();
        int n = 0;
        while (lines < 3 && n < 30000) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk_cnt("lines", 3, lines);
        chk_cnt("line_run", H_ACTIVE, last_run);
        chk_cnt("line_gap", H_BLANK, min_gap);
        chk_cnt("order_err", 0, order_err);
        chk_cnt("side_err", 0, side_err);
        chk_bit("mem_access_ok_o", 1'b0, mem_access_ok_o);
    endtask

    // Starve the buffer: timing must go on and flag the gap
    task automatic t_underrun();
        int n = 0;
        @(posedge sys_clk_i);
        feed_en <= 1'b0;
        while (underrun_o !== 1'b1 && n < 6000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_bit("underrun_o", 1'b1, underrun_o);
        chk_bit("pixel_valid_o", 1'b1, pixel_valid_o);
    endtask

    initial begin
        repeat (15) @(posedge sys_clk_i);
        t_reset_state();
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_buffer_full();
        t_backlight();
        t_lines();
        t_underrun();
        conclude();
    end

    initial begin
        repeat (60000) @(posedge sys_clk_i);
        failures++;
        conclude();
    end
endmodule

/* File: tb/tde_panel_model.sv */
// Panel-side model: takes the data-enable stream at each dot clock rise
`timescale 1ns/10ps

module tde_panel_model
    import tde_pkg::*;
(
    input  wire logic             dot_clk_i,
    input  wire logic [PIX_W-1:0] rgb_i,
    input  wire logic             pixel_valid_i,
    input  wire logic             frame_sync_n_i,
    input  wire logic             line_sync_n_i,
    input  wire logic             mem_ok_i,
    output int                    lines_o,
    output int                    last_run_o,
    output int                    min_gap_o,
    output int                    order_err_o,
    output int                    side_err_o
);
    int               run_cnt = 0;
    int               gap_cnt = 0;
    logic [PIX_W-1:0] exp_word = 16'h0000;

    initial begin
        lines_o = 0;
        last_run_o = 0;
        min_gap_o = 9999;
        order_err_o = 0;
        side_err_o = 0;
    end

    // Sampled at the next dot rise after launch, so the word has settled
    always @(posedge dot_clk_i) begin
        if (frame_sync_n_i !== SYNC_IDLE || line_sync_n_i !== SYNC_IDLE)
            side_err_o++;
        if (pixel_valid_i === 1'b1) begin
            if (mem_ok_i !== 1'b0)
                side_err_o++;
            if (rgb_i !== exp_word)
                order_err_o++;
            exp_word = rgb_i + 16'h0001;
            if (run_cnt == 0 && lines_o > 0 && gap_cnt < min_gap_o)
                min_gap_o = gap_cnt;
            run_cnt++;
            gap_cnt = 0;
        end else begin
            if (run_cnt > 0) begin
                lines_o++;
                last_run_o = run_cnt;
            end
            run_cnt = 0;
            // A real panel drops to self-test if this never ends
            gap_cnt++;
        end
    end
endmodule
